// ---- design/afcw_regs.sv ----
// control word and second emitter sample window registers behind a serial port
`timescale 1ns/100ps
`default_nettype none
module afcw_regs
	import afcw_pkg::*;
#(
	parameter logic [FAULT_FLAG_WORD_W-1:0] FAULT_FLAG_WORD_CYCLES = FAULT_FLAG_WORD_CYCLES_DEF
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// serial register port
	input wire logic sclk,
	input wire logic ste_n,
	input wire logic simo,
	output logic somi,
	output logic somi_oe,
	// timer engine
	input wire logic [CNT_W-1:0] repetition_period_count,
	output logic timebase_hold,
	output logic sample_window,
	// diagnostics
	input wire logic [FAULT_W-1:0] fault_status,
	output logic [FAULT_W-1:0] fault_flag_word,
	output logic fault_check_busy,
	output logic soft_restart_pulse
);

	//------------------------------------------------------------------------
	// decoding helpers
	//------------------------------------------------------------------------
	function automatic logic [DATA_W-1:0] read_word(
		input logic [ADDR_W-1:0] addr,
		input afcw_win_s win
	);
		logic [DATA_W-1:0] word;
		word = '0;
		case (addr)
			ADDR_BEGIN: word = {8'h00, win.begin_count};
			ADDR_FINISH: word = {8'h00, win.finish_count};
			default: word = '0;
		endcase
		return word;
	endfunction

	function automatic logic is_read(
		input logic [ADDR_W-1:0] addr,
		input logic readback_en
	);
		// the control word is always written, so readback can be left
		return readback_en && (addr != ADDR_CONTROL);
	endfunction

	//------------------------------------------------------------------------
	// pin synchronisers
	//------------------------------------------------------------------------
	logic [2:0] pin_in;
	logic [2:0] pin_s1_reg;
	logic [2:0] pin_s2_reg;
	logic sclk_d_reg;

	assign pin_in = {sclk, ste_n, simo};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			always_ff @(posedge clock) begin
				if (!rst_n) begin
					pin_s1_reg[gi] <= PIN_RST[gi];
					pin_s2_reg[gi] <= PIN_RST[gi];
				end else begin
					pin_s1_reg[gi] <= pin_in[gi];
					pin_s2_reg[gi] <= pin_s1_reg[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sclk_d_reg <= 1'b0;
		end else begin
			sclk_d_reg <= pin_s2_reg[PIN_SCLK];
		end
	end

	logic sclk_rise;
	logic sclk_fall;
	logic selected;
	logic simo_s;

	assign sclk_rise = pin_s2_reg[PIN_SCLK] && !sclk_d_reg;
	assign sclk_fall = !pin_s2_reg[PIN_SCLK] && sclk_d_reg;
	assign selected = !pin_s2_reg[PIN_STE];
	assign simo_s = pin_s2_reg[PIN_SIMO];

	//------------------------------------------------------------------------
	// serial frame engine
	//------------------------------------------------------------------------
	afcw_spi_e spi_state_reg;
	afcw_spi_e spi_state_next;
	logic [BIT_W-1:0] bit_cnt_reg;
	logic [BIT_W-1:0] bit_cnt_next;
	logic [ADDR_W-1:0] addr_reg;
	logic [ADDR_W-1:0] addr_next;
	logic [DATA_W-1:0] in_shift_reg;
	logic [DATA_W-1:0] in_shift_next;
	logic [DATA_W-1:0] out_shift_reg;
	logic [DATA_W-1:0] out_shift_next;
	logic somi_reg;
	logic somi_next;
	logic oe_reg;
	logic oe_next;
	logic rd_reg;
	logic rd_next;
	logic wr_fire;
	logic [DATA_W-1:0] wr_data;
	afcw_ctrl_s ctrl_reg;
	afcw_win_s win_reg;

	always_comb begin
		spi_state_next = spi_state_reg;
		bit_cnt_next = bit_cnt_reg;
		addr_next = addr_reg;
		in_shift_next = in_shift_reg;
		out_shift_next = out_shift_reg;
		somi_next = somi_reg;
		oe_next = oe_reg;
		rd_next = rd_reg;
		wr_fire = 1'b0;
		wr_data = {in_shift_reg[DATA_W-2:0], simo_s};
		if (!selected) begin
			// a frame cut short by deselect is dropped whole
			spi_state_next = SPI_IDLE;
			bit_cnt_next = '0;
			somi_next = 1'b0;
			oe_next = 1'b0;
			rd_next = 1'b0;
		end else begin
			case (spi_state_reg)
				SPI_IDLE: begin
					spi_state_next = SPI_ADDR;
					bit_cnt_next = '0;
				end
				SPI_ADDR: begin
					if (sclk_rise) begin
						addr_next = {addr_reg[ADDR_W-2:0], simo_s};
						bit_cnt_next = bit_cnt_reg + 1'b1;
						if (bit_cnt_reg == ADDR_LAST) begin
							spi_state_next = SPI_DATA;
							bit_cnt_next = '0;
							rd_next = is_read(addr_next, ctrl_reg.readback_en);
							out_shift_next = read_word(addr_next, win_reg);
							oe_next = rd_next;
						end
					end
				end
				SPI_DATA: begin
					if (sclk_rise) begin
						in_shift_next = wr_data;
						bit_cnt_next = bit_cnt_reg + 1'b1;
						if (bit_cnt_reg == DATA_LAST) begin
							spi_state_next = SPI_END;
							wr_fire = !rd_reg;
						end
					end
					if (sclk_fall && rd_reg) begin
						somi_next = out_shift_reg[DATA_W-1];
						out_shift_next = {out_shift_reg[DATA_W-2:0], 1'b0};
					end
				end
				SPI_END: begin
					spi_state_next = SPI_END;
				end
				default: begin
					spi_state_next = SPI_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			spi_state_reg <= SPI_IDLE;
			bit_cnt_reg <= '0;
			addr_reg <= '0;
			in_shift_reg <= '0;
			out_shift_reg <= '0;
			somi_reg <= 1'b0;
			oe_reg <= 1'b0;
			rd_reg <= 1'b0;
		end else begin
			spi_state_reg <= spi_state_next;
			bit_cnt_reg <= bit_cnt_next;
			addr_reg <= addr_next;
			in_shift_reg <= in_shift_next;
			out_shift_reg <= out_shift_next;
			somi_reg <= somi_next;
			oe_reg <= oe_next;
			rd_reg <= rd_next;
		end
	end

	//------------------------------------------------------------------------
	// register file and diagnostic sequence
	//------------------------------------------------------------------------
	afcw_ctrl_s ctrl_next;
	afcw_ctrl_s ctrl_wr;
	afcw_win_s win_next;
	logic [FAULT_FLAG_WORD_W-1:0] fault_flag_word_cnt_reg;
	logic [FAULT_FLAG_WORD_W-1:0] fault_flag_word_cnt_next;
	logic [FAULT_W-1:0] fault_reg;
	logic [FAULT_W-1:0] fault_next;
	logic fault_flag_word_done;

	assign ctrl_wr = afcw_ctrl_s'(wr_data[CTRL_W-1:0]);
	assign fault_flag_word_done = ctrl_reg.fault_check_trigger
		&& (fault_flag_word_cnt_reg == FAULT_FLAG_WORD_CYCLES - 1'b1);

	always_comb begin
		ctrl_next = ctrl_reg;
		win_next = win_reg;
		fault_flag_word_cnt_next = fault_flag_word_cnt_reg;
		fault_next = fault_reg;
		if (ctrl_reg.soft_restart_bit) begin
			// the pulse itself is one of the registers it clears
			ctrl_next = afcw_ctrl_s'(CTRL_RST);
			win_next = '{begin_count: COUNT_RST, finish_count: COUNT_RST};
			fault_flag_word_cnt_next = '0;
			fault_next = FAULT_RST;
		end else begin
			if (ctrl_reg.fault_check_trigger) begin
				fault_flag_word_cnt_next = fault_flag_word_cnt_reg + 1'b1;
				if (fault_flag_word_done) begin
					ctrl_next.fault_check_trigger = 1'b0;
					fault_flag_word_cnt_next = '0;
					fault_next = fault_status;
				end
			end
			if (wr_fire) begin
				case (addr_reg)
					ADDR_CONTROL: begin
						ctrl_next.timebase_hold = ctrl_wr.timebase_hold;
						ctrl_next.readback_en = ctrl_wr.readback_en;
						// a new trigger wins over a finishing run and restarts it
						if (ctrl_wr.fault_check_trigger) begin
							ctrl_next.fault_check_trigger = 1'b1;
							fault_flag_word_cnt_next = '0;
						end
						if (ctrl_wr.soft_restart_bit) begin
							ctrl_next.soft_restart_bit = 1'b1;
						end
					end
					ADDR_BEGIN: begin
						win_next.begin_count = wr_data[CNT_W-1:0];
					end
					ADDR_FINISH: begin
						win_next.finish_count = wr_data[CNT_W-1:0];
					end
					default: begin
						win_next = win_reg;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ctrl_reg <= afcw_ctrl_s'(CTRL_RST);
			win_reg <= '{begin_count: COUNT_RST, finish_count: COUNT_RST};
			fault_flag_word_cnt_reg <= '0;
			fault_reg <= FAULT_RST;
		end else begin
			ctrl_reg <= ctrl_next;
			win_reg <= win_next;
			fault_flag_word_cnt_reg <= fault_flag_word_cnt_next;
			fault_reg <= fault_next;
		end
	end

	//------------------------------------------------------------------------
	// window timer
	//------------------------------------------------------------------------
	afcw_window_timer i_afcw_window_timer (
		.clock(clock),
		.rst_n(rst_n),
		.restart(ctrl_reg.soft_restart_bit),
		.hold(ctrl_reg.timebase_hold),
		.repetition_period_count(repetition_period_count),
		.win(win_reg),
		.sample_window(sample_window)
	);

	//------------------------------------------------------------------------
	// outputs
	//------------------------------------------------------------------------
	assign somi = somi_reg;
	assign somi_oe = oe_reg;
	assign timebase_hold = ctrl_reg.timebase_hold;
	assign fault_flag_word = fault_reg;
	assign fault_check_busy = ctrl_reg.fault_check_trigger;
	assign soft_restart_pulse = ctrl_reg.soft_restart_bit;

	//------------------------------------------------------------------------
	// checks
	//------------------------------------------------------------------------
	logic rst_seen_reg;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rst_seen_reg <= 1'b1;
		end else begin
			rst_seen_reg <= 1'b0;
		end
	end

	property p_ctrl_unread;
		@(posedge clock) disable iff (!rst_n)
		somi_oe |-> (addr_reg != ADDR_CONTROL);
	endproperty
	a_ctrl_unread: assert property (p_ctrl_unread)
		else $error("control word driven out on the serial port");

	property p_restart_clears;
		@(posedge clock) disable iff (!rst_n)
		soft_restart_pulse |=> !soft_restart_pulse && !timebase_hold
			&& !fault_check_busy && (win_reg == '0) && (fault_flag_word == '0);
	endproperty
	a_restart_clears: assert property (p_restart_clears)
		else $error("soft restart left a register off its default");

	property p_trigger_starts;
		@(posedge clock) disable iff (!rst_n)
		(wr_fire && addr_reg == ADDR_CONTROL && ctrl_wr.fault_check_trigger
			&& !soft_restart_pulse) |=> fault_check_busy && fault_flag_word_cnt_reg == '0;
	endproperty
	a_trigger_starts: assert property (p_trigger_starts)
		else $error("fault check did not start on trigger");

	property p_flags_stored;
		@(posedge clock) disable iff (!rst_n)
		(fault_flag_word_done && !soft_restart_pulse)
			|=> fault_flag_word == $past(fault_status);
	endproperty
	a_flags_stored: assert property (p_flags_stored)
		else $error("fault statuses not stored at end of sequence");

	property p_trigger_length;
		@(posedge clock) disable iff (!rst_n)
		$fell(fault_check_busy) && !$past(soft_restart_pulse)
			|-> $past(fault_flag_word_cnt_reg) == FAULT_FLAG_WORD_CYCLES - 1'b1;
	endproperty
	a_trigger_length: assert property (p_trigger_length)
		else $error("fault check ended off its length");

	property p_busy_bounded;
		@(posedge clock) disable iff (!rst_n)
		fault_check_busy |-> fault_flag_word_cnt_reg < FAULT_FLAG_WORD_CYCLES;
	endproperty
	a_busy_bounded: assert property (p_busy_bounded)
		else $error("fault check ran past its length");

	property p_read_needs_enable;
		@(posedge clock) disable iff (!rst_n)
		$rose(somi_oe) |-> $past(ctrl_reg.readback_en) && selected;
	endproperty
	a_read_needs_enable: assert property (p_read_needs_enable)
		else $error("readback driven while readback is disabled");

	property p_reset_values;
		@(posedge clock) disable iff (!rst_n)
		rst_seen_reg |-> (ctrl_reg == afcw_ctrl_s'(CTRL_RST))
			&& (win_reg == '0) && !somi_oe;
	endproperty
	a_reset_values: assert property (p_reset_values)
		else $error("registers not at zero after reset");

endmodule
`default_nettype wire

// ---- common/afcw_pkg.sv ----
// package: constants, types and field layout of the sample window registers
//----------------------------------------------------------------------------
//----------------------------------------------------------------------------
package afcw_pkg;

	//------------------------------------------------------------------------
	// clock and timing
	//------------------------------------------------------------------------
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned TB_HZ = 4_000_000;
	localparam int unsigned TB_DIV = CLK_HZ / TB_HZ;
	localparam int unsigned TB_DIV_W = 5;
	localparam logic [TB_DIV_W-1:0] TB_LAST = TB_DIV_W'(TB_DIV - 1);
	localparam int unsigned FAULT_FLAG_WORD_MS = 16;
	localparam int unsigned FAULT_FLAG_WORD_W = 21;
	localparam logic [FAULT_FLAG_WORD_W-1:0] FAULT_FLAG_WORD_CYCLES_DEF =
		FAULT_FLAG_WORD_W'(FAULT_FLAG_WORD_MS * (CLK_HZ / 1000));

	//------------------------------------------------------------------------
	// serial frame and register map
	//------------------------------------------------------------------------
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 24;
	localparam int unsigned CNT_W = 16;
	localparam int unsigned BIT_W = 5;
	localparam logic [BIT_W-1:0] ADDR_LAST = 5'h07;
	localparam logic [BIT_W-1:0] DATA_LAST = 5'h17;
	localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_BEGIN = 8'h01;
	localparam logic [ADDR_W-1:0] ADDR_FINISH = 8'h02;
	localparam int unsigned CTRL_W = 4;
	localparam int unsigned BIT_SOFT_RESTART = 3;
	localparam int unsigned BIT_FAULT_CHECK = 2;
	localparam int unsigned BIT_TIMEBASE_HOLD = 1;
	localparam int unsigned BIT_READBACK = 0;
	localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
	localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;
	localparam int unsigned FAULT_W = 13;
	localparam logic [FAULT_W-1:0] FAULT_RST = 13'h0000;
	// sclk, ste_n, simo as they sit in the synchroniser vector
	localparam logic [2:0] PIN_RST = 3'h2;
	localparam int unsigned PIN_SCLK = 2;
	localparam int unsigned PIN_STE = 1;
	localparam int unsigned PIN_SIMO = 0;

	//------------------------------------------------------------------------
	// types
	//------------------------------------------------------------------------
	// field order follows bits 3..0 of the control word
	typedef struct packed {
		logic soft_restart_bit;
		logic fault_check_trigger;
		logic timebase_hold;
		logic readback_en;
	} afcw_ctrl_s;

	typedef struct packed {
		logic [CNT_W-1:0] begin_count;
		logic [CNT_W-1:0] finish_count;
	} afcw_win_s;

	typedef enum logic [1:0] {
		SPI_IDLE = 2'h0,
		SPI_ADDR = 2'h1,
		SPI_DATA = 2'h3,
		SPI_END = 2'h2
	} afcw_spi_e;

endpackage

// ---- design/afcw_window_timer.sv ----
// window timer: 4 MHz timebase, repetition period counter, sample window
`timescale 1ns/100ps
`default_nettype none
module afcw_window_timer
	import afcw_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// control
	input wire logic restart,
	input wire logic hold,
	input wire logic [CNT_W-1:0] repetition_period_count,
	input wire afcw_win_s win,
	// result
	output logic sample_window
);

	logic [TB_DIV_W-1:0] div_reg;
	logic [TB_DIV_W-1:0] div_next;
	logic [CNT_W-1:0] period_reg;
	logic [CNT_W-1:0] period_next;
	logic win_reg;
	logic win_next;
	logic tick;

	assign tick = (div_reg == TB_LAST);

	//------------------------------------------------------------------------
	// counters and window
	//------------------------------------------------------------------------
	always_comb begin
		div_next = tick ? '0 : div_reg + 1'b1;
		period_next = period_reg;
		win_next = win_reg;
		if (tick) begin
			if (period_reg >= repetition_period_count) begin
				period_next = '0;
			end else begin
				period_next = period_reg + 1'b1;
			end
			// equal counts give an empty window: the finish compare wins
			if (period_reg == win.finish_count) begin
				win_next = 1'b0;
			end else if (period_reg == win.begin_count) begin
				win_next = 1'b1;
			end
		end
		if (hold || restart) begin
			div_next = '0;
			period_next = '0;
			win_next = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			div_reg <= '0;
			period_reg <= '0;
			win_reg <= 1'b0;
		end else begin
			div_reg <= div_next;
			period_reg <= period_next;
			win_reg <= win_next;
		end
	end

	assign sample_window = win_reg;

	//------------------------------------------------------------------------
	// checks
	//------------------------------------------------------------------------
	property p_hold_clears;
		@(posedge clock) disable iff (!rst_n)
		hold |=> (period_reg == '0) && !sample_window && (div_reg == '0);
	endproperty
	a_hold_clears: assert property (p_hold_clears)
		else $error("counters not held while timebase hold is set");

	property p_window_opens;
		@(posedge clock) disable iff (!rst_n)
		(tick && !hold && !restart && period_reg == win.begin_count
			&& period_reg != win.finish_count) |=> sample_window;
	endproperty
	a_window_opens: assert property (p_window_opens)
		else $error("window did not open at the begin count");

	property p_window_closes;
		@(posedge clock) disable iff (!rst_n)
		(tick && period_reg == win.finish_count) |=> !sample_window
			##1 (!sample_window)[*3];
	endproperty
	a_window_closes: assert property (p_window_closes)
		else $error("window open after the finish count");

endmodule
`default_nettype wire

// ---- sim/afcw_host.sv ----
// host model: master of the serial register port
`timescale 1ns/100ps
`default_nettype none
module afcw_host
	import afcw_pkg::*;
(
	// clock
	input wire logic clock,
	// serial register port
	output logic sclk,
	output logic ste_n,
	output logic simo,
	input wire logic somi,
	input wire logic somi_oe
);
	localparam int HALF = 5;
	logic [DATA_W-1:0] rdata;
	logic oe_seen;

	initial begin
		sclk = 1'b0;
		ste_n = 1'b1;
		simo = 1'b0;
		rdata = '0;
		oe_seen = 1'b0;
	end

	// oe is watched every clock, so its tail after deselect is seen too
	task automatic step(input int n);
		repeat (n) begin
			@(posedge clock);
			oe_seen = oe_seen | (somi_oe === 1'b1);
		end
	endtask

	// one frame, msb first; sclk stands still low outside frames
	task automatic frame(input logic [ADDR_W-1:0] addr,
			input logic [DATA_W-1:0] data);
		logic [DATA_W-1:0] d;
		logic [ADDR_W+DATA_W-1:0] word;
		d = data & 24'h00ffff;
		if (addr == ADDR_CONTROL) begin
			d = data & 24'h00000f;
		end
		word = {addr, d};
		oe_seen = 1'b0;
		ste_n <= 1'b0;
		for (int i = ADDR_W + DATA_W - 1; i >= 0; i--) begin
			simo <= word[i];
			step(HALF);
			sclk <= 1'b1;
			rdata = {rdata[DATA_W-2:0], somi};
			step(HALF);
			sclk <= 1'b0;
		end
		step(HALF);
		ste_n <= 1'b1;
		// released line: never leave the last bit standing
		simo <= ~simo;
		step(HALF);
	endtask
endmodule
`default_nettype wire

// ---- sim/afe_control_sample_window_regs_bench.sv ----
// testbench of the control word and sample window registers
`timescale 1ns/100ps
`default_nettype none
module afe_control_sample_window_regs_bench
	import afcw_pkg::*;
;
	localparam logic [FAULT_FLAG_WORD_W-1:0] FAULT_FLAG_WORD_SIM = 21'h32;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic sclk, ste_n, simo, somi, somi_oe;
	logic [CNT_W-1:0] repetition_period_count = 16'h0031;
	logic [FAULT_W-1:0] fault_status = 13'h0000;
	logic timebase_hold, sample_window, fault_check_busy, soft_restart_pulse;
	logic [FAULT_W-1:0] fault_flag_word;
	logic [31:0] seed = 32'h73c3;
	logic [31:0] r;
	int n_errors = 0;
	int n_compared = 0;
	int hi_run = 0, lo_run = 0, hi_last = 0, lo_last = 0, hi_total = 0;
	int busy_run = 0, busy_last = 0, pul_run = 0, pul_last = 0;
	int b, f, p, snap;

	always #5 clock = ~clock;

	afcw_regs #(.FAULT_FLAG_WORD_CYCLES(FAULT_FLAG_WORD_SIM)) i_afcw_regs (
		.clock(clock), .rst_n(rst_n), .sclk(sclk), .ste_n(ste_n),
		.simo(simo), .somi(somi), .somi_oe(somi_oe),
		.repetition_period_count(repetition_period_count),
		.timebase_hold(timebase_hold), .sample_window(sample_window),
		.fault_status(fault_status), .fault_flag_word(fault_flag_word),
		.fault_check_busy(fault_check_busy),
		.soft_restart_pulse(soft_restart_pulse));

	afcw_host i_afcw_host (.clock(clock), .sclk(sclk), .ste_n(ste_n),
		.simo(simo), .somi(somi), .somi_oe(somi_oe));

	// run lengths of the window, the busy flag and the restart pulse
	always @(posedge clock) begin
		if (sample_window === 1'b1) begin
			hi_run++;
			hi_total++;
			if (lo_run != 0) lo_last = lo_run;
			lo_run = 0;
		end else begin
			lo_run++;
			if (hi_run != 0) hi_last = hi_run;
			hi_run = 0;
		end
		if (fault_check_busy === 1'b1) busy_run++;
		else if (busy_run != 0) busy_last = busy_run;
		if (fault_check_busy !== 1'b1) busy_run = 0;
		if (soft_restart_pulse === 1'b1) pul_run++;
		else if (pul_run != 0) pul_last = pul_run;
		if (soft_restart_pulse !== 1'b1) pul_run = 0;
	end

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [DATA_W-1:0] ticks(input int n);
		return DATA_W'(n * int'(TB_DIV));
	endfunction

	task automatic chk(input string what, input logic [DATA_W-1:0] exp,
			input logic [DATA_W-1:0] got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		i_afcw_host.frame(a, d);
		chk("somi_oe in write", 24'h0, 24'(i_afcw_host.oe_seen));
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		i_afcw_host.frame(a, 24'h0);
		chk("somi_oe in read", 24'h1, 24'(i_afcw_host.oe_seen));
		chk("read data", e, i_afcw_host.rdata);
	endtask

	task automatic conclude();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		repeat (4) @(posedge clock);
		chk("outputs after reset", 24'h0, 24'({timebase_hold,
			sample_window, fault_check_busy, somi_oe, fault_flag_word}));
		wr(ADDR_CONTROL, 24'h000001);
		rd(ADDR_BEGIN, 24'h0);
		rd(ADDR_FINISH, 24'h0);
		// random windows; readback must be off to write counts
		for (int k = 0; k < 3; k++) begin
			seed = lfsr_next(seed);
			r = seed;
			b = 1 + int'(r[4:0]) % 20;
			f = b + 1 + int'(r[12:8]) % 20;
			p = f + 1 + int'(r[18:16]);
			repetition_period_count <= 16'(p);
			wr(ADDR_CONTROL, 24'h000000);
			wr(ADDR_BEGIN, {r[31:24], 16'(b)});
			wr(ADDR_FINISH, 24'(f));
			wr(ADDR_CONTROL, 24'h000001);
			rd(ADDR_BEGIN, 24'(b));
			rd(ADDR_FINISH, 24'(f));
			repeat (3 * (p + 1) * int'(TB_DIV)) @(posedge clock);
			chk("window open", ticks(f - b), 24'(hi_last));
			chk("window closed", ticks(p + 1 - f + b), 24'(lo_last));
		end
		wr(ADDR_CONTROL, 24'h000003);
		chk("timebase_hold set", 24'h1, 24'(timebase_hold));
		snap = hi_total;
		repeat (2 * (p + 1) * int'(TB_DIV)) @(posedge clock);
		chk("window while held", 24'h0, 24'(hi_total - snap));
		wr(ADDR_CONTROL, 24'h000001);
		chk("timebase_hold clear", 24'h0, 24'(timebase_hold));
		for (int k = 0; k < 2; k++) begin
			seed = lfsr_next(seed);
			fault_status <= seed[FAULT_W-1:0];
			wr(ADDR_CONTROL, 24'h000005);
			chk("busy during check", 24'h1, 24'(fault_check_busy));
			for (int w = 0; fault_check_busy !== 1'b0; w++) begin
				if (w > 200) begin
					n_errors++;
					conclude();
				end
				@(posedge clock);
			end
			@(posedge clock);
			chk("check length", 24'(FAULT_FLAG_WORD_SIM), 24'(busy_last));
			chk("fault flags", 24'(seed[FAULT_W-1:0]),
				24'(fault_flag_word));
		end
		wr(ADDR_CONTROL, 24'h000008);
		chk("restart pulse", 24'h1, 24'(pul_last));
		chk("flags after restart", 24'h0, 24'(fault_flag_word));
		wr(ADDR_CONTROL, 24'h000001);
		rd(ADDR_BEGIN, 24'h0);
		rd(ADDR_FINISH, 24'h0);
		conclude();
	end
endmodule
`default_nettype wire
